//--- rtl/sdmmc_dma_defs.vh
// constants shared by the descriptor dma engine, its assertions and its bench
`ifndef SDMMC_DMA_DEFS_VH
`define SDMMC_DMA_DEFS_VH
`define OFF_CTRL       8'h00
`define OFF_POLL       8'h04
`define OFF_BASE       8'h08
`define OFF_STAT       8'h0c
`define OFF_WIN        8'h10
`define OFF_CUR        8'h14
`define CTRL_W         5
`define CTRL_RST       5'h00
`define CTRL_DMA_EN    0
`define CTRL_SEND_EN   1
`define CTRL_DIR_TX    2
`define CTRL_TXDONE_EN 3
`define CTRL_RXDONE_EN 4
`define STAT_W         3
`define STAT_RST       3'h0
`define STAT_TX        0
`define STAT_RX        1
`define STAT_UNAVAIL   2
`define D0_OWN         31
`define D0_SUM         30
`define D0_RING        5
`define D0_LINK        4
`define D0_FIRST       3
`define D0_LAST        2
`define D0_MUTE        1
`define D1_SIZE_HI     12
`define SIZE_W         13
`define SIZE_STEP      13'h0004
`define WORD_BYTES     32'h0000_0004
`define DESC_BYTES     32'h0000_0010
`define FAULT_W        7
`define RAM_AW         4
`define RAM_DEPTH      5'h10
`define CNT_W          5
`endif

//--- rtl/buf_ram.v
// one buffer region: single write port, registered read port
module buf_ram #(
    parameter AW = 4,
    parameter DW = 32
) (
    input  wire          clk,
    input  wire          rst_n,
    input  wire          we,
    input  wire [AW-1:0] waddr,
    input  wire [DW-1:0] wdata,
    input  wire          re,
    input  wire [AW-1:0] raddr,
    output reg  [DW-1:0] rdata_q
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    always @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= {DW{1'b0}};
        end else if (re) begin
            rdata_q <= mem[raddr];
        end
    end
endmodule // buf_ram

//--- rtl/sdmmc_descriptor_dma.v
// descriptor driven dma engine with transmit and receive buffer regions
`include "sdmmc_dma_defs.vh"
module sdmmc_descriptor_dma (
    input  wire                 pclk,
    input  wire                 presetn,
    input  wire [7:0]           paddr,
    input  wire                 psel,
    input  wire                 penable,
    input  wire                 pwrite,
    input  wire [31:0]          pwdata,
    output reg  [31:0]          prdata,
    output reg                  pready,
    output reg                  pslverr,
    output reg                  mem_req,
    output reg                  mem_we,
    output reg  [31:0]          mem_addr,
    output reg  [31:0]          mem_wdata,
    input  wire                 mem_ack,
    input  wire [31:0]          mem_rdata,
    input  wire                 tx_pop,
    output wire [31:0]          tx_data,
    output reg  [`CNT_W-1:0]    tx_level,
    input  wire                 rx_push,
    input  wire [31:0]          rx_wdata,
    output reg  [`CNT_W-1:0]    rx_level,
    input  wire [`FAULT_W-1:0]  card_faults
);
    localparam S_IDLE  = 3'd0;
    localparam S_FETCH = 3'd1;
    localparam S_CHECK = 3'd2;
    localparam S_SUSP  = 3'd3;
    localparam S_XFER  = 3'd4;
    localparam S_WB    = 3'd5;
    localparam S_NEXT  = 3'd6;

    function reg_hit;
        input [7:0] a;
        begin
            reg_hit = (a == `OFF_CTRL) || (a == `OFF_POLL) ||
                      (a == `OFF_BASE) || (a == `OFF_STAT) ||
                      (a == `OFF_WIN)  || (a == `OFF_CUR);
        end
    endfunction

    reg [`CTRL_W-1:0]  ctrl_q;
    reg [`STAT_W-1:0]  stat_q;
    reg [31:0]         base_q;
    reg [31:0]         nxt_q;
    reg [2:0]          st_q;
    reg [1:0]          idx_q;
    reg [31:0]         w0_q;
    reg [31:0]         w1_q;
    reg [31:0]         w2_q;
    reg [31:0]         w3_q;
    reg [31:0]         desc_q;
    reg [31:0]         ptr_q;
    reg [`SIZE_W-1:0]  rem_q;
    reg                rx_pend_q;
    reg [`RAM_AW-1:0]  tx_wp_q;
    reg [`RAM_AW-1:0]  tx_rp_q;
    reg [`RAM_AW-1:0]  rx_wp_q;
    reg [`RAM_AW-1:0]  rx_rp_q;
    wire [31:0]        rx_rdata;

    wire dir_tx   = ctrl_q[`CTRL_DIR_TX];
    wire dma_on   = ctrl_q[`CTRL_DMA_EN];
    wire acc      = psel & penable & ~pready;
    wire take     = psel & penable & pready;
    wire wr_take  = take & pwrite;
    wire win      = (paddr == `OFF_WIN);
    wire poll_wr  = wr_take & (paddr == `OFF_POLL);
    wire base_wr  = wr_take & (paddr == `OFF_BASE);
    wire mem_done = mem_req & mem_ack;
    wire tx_full  = (tx_level == `RAM_DEPTH);
    wire rx_empty = (rx_level == {`CNT_W{1'b0}});
    wire last_d   = w0_q[`D0_LAST];
    wire fault    = |card_faults;

    // dma owns the region of its direction while enabled; cpu window access to that region is shut out
    wire dma_tx   = dma_on & dir_tx;
    wire dma_rx   = dma_on & ~dir_tx;
    wire apb_push = wr_take & win & ctrl_q[`CTRL_SEND_EN] & ~dma_tx &
                    ~tx_full;
    wire dma_push = (st_q == S_XFER) & dir_tx & mem_done;
    wire tx_we    = apb_push | dma_push;
    wire tx_re    = tx_pop & (tx_level != {`CNT_W{1'b0}});
    // read issued in the setup cycle so data is ready for the access cycle
    wire apb_pop  = psel & ~penable & ~pwrite & win & ~dma_rx & ~rx_empty;
    wire dma_pop  = (st_q == S_XFER) & ~dir_tx & ~mem_req & ~rx_pend_q &
                    (rem_q != {`SIZE_W{1'b0}}) & ~rx_empty;
    wire rx_re    = apb_pop | dma_pop;
    wire rx_we    = rx_push & (rx_level != `RAM_DEPTH);

    wire [31:0] next_addr = w0_q[`D0_RING] ? base_q :
                            w0_q[`D0_LINK] ? w3_q :
                            desc_q + `DESC_BYTES;

    buf_ram #(.AW(`RAM_AW), .DW(32)) u_tx_ram (
        .clk     (pclk),
        .rst_n   (presetn),
        .we      (tx_we),
        .waddr   (tx_wp_q),
        .wdata   (dma_push ? mem_rdata : pwdata),
        .re      (tx_re),
        .raddr   (tx_rp_q),
        .rdata_q (tx_data)
    );

    buf_ram #(.AW(`RAM_AW), .DW(32)) u_rx_ram (
        .clk     (pclk),
        .rst_n   (presetn),
        .we      (rx_we),
        .waddr   (rx_wp_q),
        .wdata   (rx_wdata),
        .re      (rx_re),
        .raddr   (rx_rp_q),
        .rdata_q (rx_rdata)
    );

    // region pointers and fill levels
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_wp_q  <= {`RAM_AW{1'b0}};
            tx_rp_q  <= {`RAM_AW{1'b0}};
            rx_wp_q  <= {`RAM_AW{1'b0}};
            rx_rp_q  <= {`RAM_AW{1'b0}};
            tx_level <= {`CNT_W{1'b0}};
            rx_level <= {`CNT_W{1'b0}};
        end else begin
            if (tx_we) begin
                tx_wp_q <= tx_wp_q + 1'b1;
            end
            if (tx_re) begin
                tx_rp_q <= tx_rp_q + 1'b1;
            end
            if (rx_we) begin
                rx_wp_q <= rx_wp_q + 1'b1;
            end
            if (rx_re) begin
                rx_rp_q <= rx_rp_q + 1'b1;
            end
            tx_level <= tx_level + {{(`CNT_W-1){1'b0}}, tx_we}
                                 - {{(`CNT_W-1){1'b0}}, tx_re};
            rx_level <= rx_level + {{(`CNT_W-1){1'b0}}, rx_we}
                                 - {{(`CNT_W-1){1'b0}}, rx_re};
        end
    end

    // apb slave: one wait state, answer registered
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            ctrl_q  <= `CTRL_RST;
            base_q  <= 32'h0000_0000;
        end else begin
            pready  <= acc;
            pslverr <= acc & ~reg_hit(paddr);
            if (acc && !pwrite) begin
                case (paddr)
                    `OFF_CTRL: prdata <= {{(32-`CTRL_W){1'b0}}, ctrl_q};
                    `OFF_BASE: prdata <= base_q;
                    `OFF_STAT: prdata <= {{(29-`STAT_W){1'b0}}, st_q,
                                          stat_q};
                    `OFF_WIN:  prdata <= rx_rdata;
                    `OFF_CUR:  prdata <= desc_q;
                    default:   prdata <= 32'h0000_0000;
                endcase
            end
            if (wr_take && paddr == `OFF_CTRL) begin
                ctrl_q <= pwdata[`CTRL_W-1:0];
            end
            if (base_wr) begin
                base_q <= pwdata;
            end
        end
    end

    // status flags: write one to clear, a same-cycle set wins
    wire set_tx = (st_q == S_WB) & mem_done & last_d & ~w0_q[`D0_MUTE] &
                  dir_tx & ctrl_q[`CTRL_TXDONE_EN];
    wire set_rx = (st_q == S_WB) & mem_done & last_d & ~w0_q[`D0_MUTE] &
                  ~dir_tx & ctrl_q[`CTRL_RXDONE_EN];
    wire set_du = (st_q == S_CHECK) & ~w0_q[`D0_OWN];
    wire [`STAT_W-1:0] clr = (wr_take && paddr == `OFF_STAT) ?
                             pwdata[`STAT_W-1:0] : `STAT_RST;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q <= `STAT_RST;
        end else begin
            stat_q <= (stat_q & ~clr) | {set_du, set_rx, set_tx};
        end
    end

    // descriptor walker and host memory master
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q      <= S_IDLE;
            idx_q     <= 2'd0;
            w0_q      <= 32'h0000_0000;
            w1_q      <= 32'h0000_0000;
            w2_q      <= 32'h0000_0000;
            w3_q      <= 32'h0000_0000;
            desc_q    <= 32'h0000_0000;
            nxt_q     <= 32'h0000_0000;
            ptr_q     <= 32'h0000_0000;
            rem_q     <= {`SIZE_W{1'b0}};
            rx_pend_q <= 1'b0;
            mem_req   <= 1'b0;
            mem_we    <= 1'b0;
            mem_addr  <= 32'h0000_0000;
            mem_wdata <= 32'h0000_0000;
        end else begin
            if (base_wr) begin
                nxt_q <= pwdata;
            end
            if (mem_done) begin
                mem_req <= 1'b0;
            end
            case (st_q)
                S_IDLE: begin
                    if (dma_on && (poll_wr || base_wr)) begin
                        desc_q <= base_wr ? pwdata : nxt_q;
                        idx_q  <= 2'd0;
                        st_q   <= S_FETCH;
                    end
                end
                S_FETCH: begin
                    if (!mem_req) begin
                        mem_req  <= 1'b1;
                        mem_we   <= 1'b0;
                        mem_addr <= desc_q + {28'h0, idx_q, 2'b00};
                    end else if (mem_ack) begin
                        case (idx_q)
                            2'd0:    w0_q <= mem_rdata;
                            2'd1:    w1_q <= mem_rdata;
                            2'd2:    w2_q <= mem_rdata;
                            default: w3_q <= mem_rdata;
                        endcase
                        idx_q <= idx_q + 2'd1;
                        if (idx_q == 2'd3) begin
                            st_q <= S_CHECK;
                        end
                    end
                end
                S_CHECK: begin
                    if (!w0_q[`D0_OWN]) begin
                        st_q <= S_SUSP;
                    end else if (w1_q[`D1_SIZE_HI:0] == {`SIZE_W{1'b0}}) begin
                        st_q <= S_WB;
                    end else begin
                        rem_q <= w1_q[`D1_SIZE_HI:0];
                        ptr_q <= w2_q;
                        st_q  <= S_XFER;
                    end
                end
                S_SUSP: begin
                    if (poll_wr) begin
                        idx_q <= 2'd0;
                        st_q  <= S_FETCH;
                    end
                end
                S_XFER: begin
                    if (mem_done) begin
                        rem_q <= rem_q - `SIZE_STEP;
                        ptr_q <= ptr_q + `WORD_BYTES;
                    end else if (rx_pend_q) begin
                        rx_pend_q <= 1'b0;
                        mem_req   <= 1'b1;
                        mem_we    <= 1'b1;
                        mem_addr  <= ptr_q;
                        mem_wdata <= rx_rdata;
                    end else if (!mem_req) begin
                        if (rem_q == {`SIZE_W{1'b0}}) begin
                            st_q <= S_WB;
                        end else if (dir_tx && !tx_full) begin
                            mem_req  <= 1'b1;
                            mem_we   <= 1'b0;
                            mem_addr <= ptr_q;
                        end else if (dma_pop) begin
                            rx_pend_q <= 1'b1;
                        end
                    end
                end
                S_WB: begin
                    if (!mem_req && !mem_done) begin
                        mem_req   <= 1'b1;
                        mem_we    <= 1'b1;
                        mem_addr  <= desc_q;
                        mem_wdata <= {1'b0, fault,
                                      w0_q[`D0_SUM-1:0]};
                    end else if (mem_done) begin
                        st_q <= S_NEXT;
                    end
                end
                S_NEXT: begin
                    desc_q <= next_addr;
                    nxt_q  <= next_addr;
                    idx_q  <= 2'd0;
                    // the last descriptor ends the transfer; poll restarts
                    st_q   <= (last_d || !dma_on) ? S_IDLE : S_FETCH;
                end
                default: begin
                    st_q <= S_IDLE;
                end
            endcase
        end
    end
endmodule // sdmmc_descriptor_dma

//--- verif/sdmmc_dma_props.sv
// assertions on the ports of the descriptor dma engine
`include "sdmmc_dma_defs.vh"
module sdmmc_dma_props (
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic [7:0]         paddr,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic [31:0]        prdata,
    input wire logic               pready,
    input wire logic               pslverr,
    input wire logic               mem_req,
    input wire logic               mem_we,
    input wire logic [31:0]        mem_addr,
    input wire logic [31:0]        mem_wdata,
    input wire logic               mem_ack,
    input wire logic [`CNT_W-1:0]  tx_level,
    input wire logic               rx_push,
    input wire logic [`CNT_W-1:0]  rx_level
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_answer;
        !pready ##1 pready;
    endsequence
    chk_apb_wait:
        assert property (s_setup |=> s_answer) else $error("apb answer late");
    chk_ready_pulse:
        assert property (pready |=> !pready) else $error("pready too long");
    chk_err_unmapped:
        assert property (pready |-> pslverr == (paddr > 8'h14))
        else $error("pslverr wrong");
    chk_rdata_unmapped:
        assert property (pready && pslverr |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    chk_mem_hold:
        assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
            && $stable(mem_we) && $stable(mem_wdata))
        else $error("memory request changed");
    chk_req_drop:
        assert property (mem_ack |=> !mem_req) else $error("request kept");
    chk_addr_word:
        assert property (mem_req |-> mem_addr[1:0] == 2'b00)
        else $error("unaligned memory address");
    chk_rx_count:
        assert property (rx_push && rx_level != `RAM_DEPTH && !psel && !mem_req
            |=> rx_level == $past(rx_level) + 5'h01)
        else $error("receive level not counted");
    chk_level_max:
        assert property (tx_level <= `RAM_DEPTH && rx_level <= `RAM_DEPTH)
        else $error("region level overrun");
endmodule // sdmmc_dma_props
bind sdmmc_descriptor_dma sdmmc_dma_props u_props (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_ack(mem_ack), .tx_level(tx_level),
    .rx_push(rx_push), .rx_level(rx_level)
);

//--- verif/host_mem_model.sv
// host memory model answering the engine's single-word requests
module host_mem_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [31:0] mem_addr,
    input  wire logic [31:0] mem_wdata,
    output logic             mem_ack,
    output logic [31:0]      mem_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] mem [0:1023];
    int          delay = 0;
    int          wait_q;
    // read data toggles outside the ack cycle so a stale word never matches
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ack <= 1'b0;
            wait_q <= 0;
            mem_rdata <= 32'h0;
        end else if (!mem_ack && mem_req && wait_q >= delay) begin
            wait_q <= 0;
            mem_ack <= 1'b1;
            if (mem_we)
                mem[mem_addr[11:2]] <= mem_wdata;
            else
                mem_rdata <= mem[mem_addr[11:2]];
        end else begin
            if (!mem_ack && mem_req)
                wait_q <= wait_q + 1;
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule // host_mem_model

//--- verif/sdmmc_descriptor_dma_tb_top.sv
// self-checking bench for the descriptor dma engine
`include "sdmmc_dma_defs.vh"
module sdmmc_descriptor_dma_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, mem_addr, mem_wdata, mem_rdata;
    logic [31:0] tx_data, rx_wdata = 32'h0;
    logic pready, pslverr, mem_req, mem_we, mem_ack;
    logic tx_pop = 0, rx_push = 0;
    logic [`CNT_W-1:0] tx_level, rx_level;
    logic [`FAULT_W-1:0] card_faults = 7'h00;
    int fail_count = 0, n_checks = 0;
    sdmmc_descriptor_dma u_sdmmc_descriptor_dma (.pclk(pclk),
        .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .tx_pop(tx_pop), .tx_data(tx_data),
        .tx_level(tx_level), .rx_push(rx_push), .rx_wdata(rx_wdata),
        .rx_level(rx_level), .card_faults(card_faults));
    host_mem_model u_host_mem_model (.pclk(pclk), .presetn(presetn),
        .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    always #50 pclk = ~pclk;
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic guard(input logic expired);
        if (expired) begin
            fail_count++;
            results();
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        int k;
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        guard(k >= 50);
        r = prdata;
        chk({31'h0, pslverr}, {31'h0, a > 8'h14});
        psel <= 0;
        penable <= 0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m);
        logic [31:0] r;
        apb(1'b0, a, 32'h0, r);
        chk(r & m, e);
    endtask
    task automatic pop(input logic [31:0] e);
        @(posedge pclk);
        tx_pop <= 1;
        @(posedge pclk);
        tx_pop <= 0;
        @(negedge pclk);
        chk(tx_data, e);
    endtask
    task automatic push(input logic [31:0] d);
        @(posedge pclk);
        rx_push <= 1;
        rx_wdata <= d;
        @(posedge pclk);
        rx_push <= 0;
    endtask
    task automatic desc(input int a, input logic [31:0] d0, sz, bp, nx);
        u_host_mem_model.mem[a >> 2] = d0;
        u_host_mem_model.mem[(a >> 2) + 1] = sz;
        u_host_mem_model.mem[(a >> 2) + 2] = bp;
        u_host_mem_model.mem[(a >> 2) + 3] = nx;
    endtask
    task automatic wait_mem(input int a);
        int k;
        k = 0;
        while (u_host_mem_model.mem[a >> 2][31] !== 1'b0 && k < 3000) begin
            @(posedge pclk);
            k++;
        end
        guard(k >= 3000);
        repeat (3) @(posedge pclk);
    endtask
    task automatic wait_stat(input int b);
        logic [31:0] r;
        int k;
        k = 0;
        do begin
            apb(1'b0, `OFF_STAT, 32'h0, r);
            k++;
        end while (r[b] !== 1'b1 && k < 200);
        guard(k >= 200);
    endtask
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1;
        rd(`OFF_CTRL, 32'h0, 32'hffff_ffff);
        rd(`OFF_STAT, 32'h0, 32'h7);
        rd(8'h20, 32'h0, 32'hffff_ffff);
        wr(`OFF_WIN, 32'h0bad_0000);
        wr(`OFF_CTRL, 32'h2);
        wr(`OFF_WIN, 32'ha5a5_0001);
        wr(`OFF_WIN, 32'ha5a5_0002);
        // level moves at the accepting edge; look once it has settled
        @(negedge pclk);
        chk({27'h0, tx_level}, 32'h2);
        pop(32'ha5a5_0001);
        pop(32'ha5a5_0002);
        push(32'h5a5a_0001);
        push(32'h5a5a_0002);
        @(negedge pclk);
        chk({27'h0, rx_level}, 32'h2);
        rd(`OFF_WIN, 32'h5a5a_0001, 32'hffff_ffff);
        rd(`OFF_WIN, 32'h5a5a_0002, 32'hffff_ffff);
        // chained empty first, then contiguous, then last; slow memory
        u_host_mem_model.delay = 3;
        card_faults <= 7'h10;
        desc(32'h100, 32'h8000_0018, 32'h0, 32'h0, 32'h140);
        desc(32'h140, 32'h8000_0000, 32'h8, 32'h200, 32'hdead_beec);
        desc(32'h150, 32'h8000_0004, 32'h8, 32'h208, 32'h0);
        for (int i = 0; i < 4; i++)
            u_host_mem_model.mem[(32'h200 >> 2) + i] = 32'h1111_0000 + i;
        wr(`OFF_CTRL, 32'hf);
        // window write refused while the engine owns the transmit region
        wr(`OFF_WIN, 32'h0bad_0001);
        wr(`OFF_BASE, 32'h100);
        wait_mem(32'h150);
        chk(u_host_mem_model.mem[32'h100 >> 2], 32'h4000_0018);
        chk(u_host_mem_model.mem[32'h140 >> 2], 32'h4000_0000);
        chk(u_host_mem_model.mem[32'h150 >> 2], 32'h4000_0004);
        chk({27'h0, tx_level}, 32'h4);
        for (int i = 0; i < 4; i++)
            pop(32'h1111_0000 + i);
        rd(`OFF_STAT, 32'h1, 32'h3);
        wr(`OFF_STAT, 32'h7);
        // receive into a muted ring descriptor that software holds at first
        u_host_mem_model.delay = 0;
        card_faults <= 7'h00;
        push(32'hc0de_0001);
        desc(32'h300, 32'h0000_0026, 32'h4, 32'h380, 32'h0);
        wr(`OFF_CTRL, 32'h11);
        wr(`OFF_BASE, 32'h300);
        wait_stat(2);
        wr(`OFF_STAT, 32'h4);
        u_host_mem_model.mem[32'h300 >> 2] = 32'h8000_0026;
        wr(`OFF_POLL, 32'h0);
        wait_mem(32'h300);
        chk(u_host_mem_model.mem[32'h380 >> 2], 32'hc0de_0001);
        chk(u_host_mem_model.mem[32'h300 >> 2], 32'h0000_0026);
        rd(`OFF_STAT, 32'h0, 32'h3);
        wr(`OFF_POLL, 32'h0);
        wait_stat(2);
        rd(`OFF_CUR, 32'h0000_0300, 32'hffff_ffff);
        rd(`OFF_BASE, 32'h0000_0300, 32'hffff_ffff);
        results();
    end
endmodule // sdmmc_descriptor_dma_tb_top
